/* rtl/rcm_pkg.sv */
// constants, types and register map of the register crc and supply fault monitor
package rcm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int ARR_DEPTH = 64;

  // register map
  localparam logic [7:0] OFS_REGION0 = 8'h00;
  localparam logic [7:0] OFS_REGION1 = 8'h10;
  localparam logic [7:0] OFS_MIRROR = 8'h20;
  localparam logic [7:0] OFS_RW = 8'h30;
  localparam logic [7:0] OFS_LOCK = 8'h3f;
  localparam logic [7:0] OFS_ARR_END = 8'h3f;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_STAT = 8'h41;
  localparam logic [7:0] OFS_CRC0 = 8'h42;
  localparam logic [7:0] OFS_CRC1 = 8'h43;
  localparam logic [7:0] OFS_MCRC = 8'h44;
  localparam logic [7:0] OFS_CCRC = 8'h45;

  // last byte index of the block and continuous scans
  localparam logic [4:0] BLOCK_LAST = 5'h0f;
  localparam logic [4:0] CONT_LAST = 5'h1e;

  // crc engine
  localparam logic [3:0] CRC_POLY = 4'h9;
  localparam logic [3:0] CRC_SEED = 4'h0;

  // control register fields
  localparam int CTRL_INIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // device status two fields
  localparam int STAT_BUFCAP = 0;
  localparam int STAT_ERR0 = 1;
  localparam int STAT_ERR1 = 2;
  localparam int STAT_ERRM = 3;
  localparam int STAT_ERRC = 4;
  localparam int STAT_UV = 7;
  localparam logic [4:0] STAT_RST = 5'h00;

  // protocol modes
  typedef enum logic [1:0] {
    MODE_DSI3_CRM = 2'b00,
    MODE_DSI3_PDCM = 2'b01,
    MODE_PSI5_SYNC = 2'b10,
    MODE_PSI5_ASYNC = 2'b11
  } rcm_mode_t;

  // scanner states
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN = 2'b01,
    SCAN_CHECK = 2'b10
  } rcm_scan_t;
endpackage : rcm_pkg

/* rtl/rcm_crc4.sv */
// byte-wide 4-bit crc accumulator
`timescale 1ns/100ps
module rcm_crc4 (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic enable,
  input wire logic [7:0] dataByte,
  output logic [3:0] crcOut
);
  // one byte folded in msb first
  function automatic logic [3:0] crcByte(input logic [3:0] c, input logic [7:0] d);
    logic [3:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[3] ^ d[i];
      r = {r[2:0], 1'b0} ^ (fb ? rcm_pkg::CRC_POLY : 4'h0);
    end
    return r;
  endfunction : crcByte

  // accumulator, seeded on clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clear) begin
      crcOut <= rcm_pkg::CRC_SEED;
    end else if (enable) begin
      crcOut <= crcByte(crcOut, dataByte);
    end
  end
endmodule : rcm_crc4

/* rtl/rcm_monitor.sv */
// register crc verification and supply fault reactions
`timescale 1ns/100ps
module rcm_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // supply comparators, high when below threshold
  input wire logic busUvDet,
  input wire logic bufRailUvDet,
  input wire logic digRailUvDet,
  input wire logic anaRailUvDet,
  input wire logic bufCapLowDet,
  // protocol activity from the link engine
  input wire logic txActive,
  input wire logic cmdRxActive,
  input wire logic respTxActive,
  input wire logic diagRespActive,
  input wire logic periodStart,
  // reactions
  output logic coreRstN,
  output logic decodeEnable,
  output logic cmdDiscard,
  output logic respAbort,
  output logic skipPeriodResp,
  output logic diagCmdFlush,
  output logic crcError,
  output logic bufCapFault
);
  // register array: region zero, region one, mirror, r/w, lock
  logic [7:0] arrMem [0:rcm_pkg::ARR_DEPTH-1];
  logic [7:0] ctrl_reg;
  logic [4:0] stat_reg;
  logic [3:0] crc0_reg;
  logic [3:0] crc1_reg;
  logic [3:0] mirroredRegionCrc_reg;
  logic [3:0] contCrc_reg;
  logic [3:0] contRef_reg;
  logic contRefValid_reg;
  logic contStale_reg;
  logic uv_reg;
  rcm_pkg::rcm_scan_t scanState_reg;
  logic [1:0] job_reg;
  logic [4:0] idx_reg;
  logic [3:0] crcOut;
  logic [7:0] scanByte;
  logic [7:0] scanBase;
  logic [5:0] scanAddr;
  logic uvAny;
  logic initDone;
  logic wrArr;
  logic contDirty;
  logic [4:0] statSet;
  logic [4:0] statClr;
  rcm_pkg::rcm_mode_t mode;

  // address lies in the byte array
  function automatic logic inArray(input logic [7:0] a);
    return a <= rcm_pkg::OFS_ARR_END;
  endfunction : inArray

  // address lies in a region frozen after init complete
  function automatic logic isFrozen(input logic [7:0] a);
    return a < rcm_pkg::OFS_RW;
  endfunction : isFrozen

  // address is covered by the continuous crc
  function automatic logic inCont(input logic [7:0] a);
    return (a >= rcm_pkg::OFS_MIRROR) && (a < rcm_pkg::OFS_LOCK);
  endfunction : inCont

  // first byte of each scan job
  function automatic logic [7:0] jobBase(input logic [1:0] j);
    logic [7:0] b;
    b = rcm_pkg::OFS_MIRROR;
    if (j == 2'd0) begin
      b = rcm_pkg::OFS_REGION0;
    end else if (j == 2'd1) begin
      b = rcm_pkg::OFS_REGION1;
    end
    return b;
  endfunction : jobBase

  // combined undervoltage of all four supplies
  assign uvAny = busUvDet | bufRailUvDet | digRailUvDet | anaRailUvDet;
  assign initDone = ctrl_reg[rcm_pkg::CTRL_INIT];
  assign mode = rcm_pkg::rcm_mode_t'(ctrl_reg[rcm_pkg::CTRL_MODE_LSB +: 2]);

  // array write allowed: mirrors and otp only before init
  assign wrArr = regWrStb && inArray(regAddr) && !(initDone && isFrozen(regAddr));
  assign contDirty = wrArr && inCont(regAddr);

  // internal reset held while any supply is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      coreRstN <= 1'b0;
    end else begin
      coreRstN <= !uvAny;
    end
  end

  // registered undervoltage for edge detection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      uv_reg <= 1'b1;
    end else begin
      uv_reg <= uvAny;
    end
  end

  // decoding enabled only while every supply is good
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      decodeEnable <= 1'b0;
    end else begin
      decodeEnable <= !uvAny;
    end
  end

  // command discard, held until reception ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmdDiscard <= 1'b0;
    end else if (uvAny && cmdRxActive && !mode[1]) begin
      cmdDiscard <= 1'b1;
    end else if (!cmdRxActive) begin
      cmdDiscard <= 1'b0;
    end
  end

  // response abort, held until the transmission ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      respAbort <= 1'b0;
    end else if (uvAny && respTxActive) begin
      respAbort <= 1'b1;
    end else if (uvAny && diagRespActive && mode == rcm_pkg::MODE_DSI3_PDCM) begin
      respAbort <= 1'b1;
    end else if (!respTxActive && !diagRespActive) begin
      respAbort <= 1'b0;
    end
  end

  // periodic response skipped for the period of a lost command
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      skipPeriodResp <= 1'b0;
    end else if (uvAny && cmdRxActive && mode == rcm_pkg::MODE_DSI3_PDCM) begin
      skipPeriodResp <= 1'b1;
    end else if (periodStart) begin
      skipPeriodResp <= 1'b0;
    end
  end

  // one-cycle flush of partial diagnostic command on undervoltage onset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      diagCmdFlush <= 1'b0;
    end else begin
      diagCmdFlush <= uvAny && !uv_reg && mode == rcm_pkg::MODE_DSI3_PDCM;
    end
  end

  // buffer capacitor checked only inside a transmission window
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bufCapFault <= 1'b0;
    end else begin
      bufCapFault <= stat_reg[rcm_pkg::STAT_BUFCAP];
    end
  end

  // control register: init bit only sets, cleared by reset alone
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg <= rcm_pkg::CTRL_RST;
    end else if (regWrStb && regAddr == rcm_pkg::OFS_CTRL) begin
      ctrl_reg[rcm_pkg::CTRL_INIT] <= initDone | regWrData[rcm_pkg::CTRL_INIT];
      if (!initDone) begin
        ctrl_reg[rcm_pkg::CTRL_MODE_LSB +: 2] <= regWrData[rcm_pkg::CTRL_MODE_LSB +: 2];
      end
    end
  end

  // expected block crcs, writable only before init
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      crc0_reg <= rcm_pkg::CRC_SEED;
      crc1_reg <= rcm_pkg::CRC_SEED;
      mirroredRegionCrc_reg <= rcm_pkg::CRC_SEED;
    end else if (regWrStb && !initDone) begin
      if (regAddr == rcm_pkg::OFS_CRC0) begin
        crc0_reg <= regWrData[3:0];
      end else if (regAddr == rcm_pkg::OFS_CRC1) begin
        crc1_reg <= regWrData[3:0];
      end else if (regAddr == rcm_pkg::OFS_MCRC) begin
        mirroredRegionCrc_reg <= regWrData[3:0];
      end
    end
  end

  // byte array storage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < rcm_pkg::ARR_DEPTH; i++) begin
        arrMem[i] <= 8'h00;
      end
    end else if (wrArr) begin
      arrMem[regAddr[5:0]] <= regWrData;
    end
  end

  // crc scanner feeds one byte per cycle
  assign scanBase = jobBase(job_reg);
  assign scanAddr = scanBase[5:0] + {1'b0, idx_reg};
  assign scanByte = arrMem[scanAddr];

  rcm_crc4 u_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(scanState_reg == rcm_pkg::SCAN_IDLE),
    .enable(scanState_reg == rcm_pkg::SCAN_RUN),
    .dataByte(scanByte),
    .crcOut(crcOut)
  );

  // scanner state machine: region zero, region one, mirror, then continuous once init is done
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scanState_reg <= rcm_pkg::SCAN_IDLE;
      job_reg <= 2'd0;
      idx_reg <= 5'h00;
    end else begin
      case (scanState_reg)
        rcm_pkg::SCAN_IDLE: begin
          idx_reg <= 5'h00;
          scanState_reg <= rcm_pkg::SCAN_RUN;
        end
        rcm_pkg::SCAN_RUN: begin
          if (idx_reg == ((job_reg == 2'd3) ? rcm_pkg::CONT_LAST : rcm_pkg::BLOCK_LAST)) begin
            scanState_reg <= rcm_pkg::SCAN_CHECK;
          end else begin
            idx_reg <= idx_reg + 5'h01;
          end
        end
        rcm_pkg::SCAN_CHECK: begin
          scanState_reg <= rcm_pkg::SCAN_IDLE;
          if (job_reg == 2'd2) begin
            job_reg <= initDone ? 2'd3 : 2'd0;
          end else if (job_reg == 2'd3) begin
            job_reg <= 2'd0;
          end else begin
            job_reg <= job_reg + 2'd1;
          end
        end
        default: begin
          scanState_reg <= rcm_pkg::SCAN_IDLE;
        end
      endcase
    end
  end

  // continuous crc result and reference capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      contCrc_reg <= rcm_pkg::CRC_SEED;
      contRef_reg <= rcm_pkg::CRC_SEED;
      contRefValid_reg <= 1'b0;
      contStale_reg <= 1'b0;
    end else if (contDirty) begin
      contRefValid_reg <= 1'b0; // legal r/w update, recapture next pass
      contStale_reg <= 1'b1; // a pass in flight may have read the old byte
    end else if (scanState_reg == rcm_pkg::SCAN_IDLE && job_reg == 2'd3) begin
      contStale_reg <= 1'b0; // a fresh pass reads settled data only
    end else if (scanState_reg == rcm_pkg::SCAN_CHECK && job_reg == 2'd3) begin
      contCrc_reg <= crcOut;
      if (!contRefValid_reg && !contStale_reg) begin
        contRef_reg <= crcOut;
        contRefValid_reg <= 1'b1;
      end
    end
  end

  // sticky status events
  always_comb begin
    statSet = 5'h00;
    statSet[rcm_pkg::STAT_BUFCAP] = txActive && bufCapLowDet;
    if (scanState_reg == rcm_pkg::SCAN_CHECK) begin
      if (job_reg == 2'd0) begin
        statSet[rcm_pkg::STAT_ERR0] = crcOut != crc0_reg;
      end else if (job_reg == 2'd1) begin
        statSet[rcm_pkg::STAT_ERR1] = crcOut != crc1_reg;
      end else if (job_reg == 2'd2) begin
        statSet[rcm_pkg::STAT_ERRM] = crcOut != mirroredRegionCrc_reg;
      end else begin
        statSet[rcm_pkg::STAT_ERRC] = contRefValid_reg && !contDirty && crcOut != contRef_reg;
      end
    end
  end

  // write one to clear, a set in the same cycle wins
  assign statClr = (regWrStb && regAddr == rcm_pkg::OFS_STAT) ? regWrData[4:0] : 5'h00;

  // device status two register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_reg <= rcm_pkg::STAT_RST;
    end else begin
      stat_reg <= (stat_reg & ~statClr) | statSet;
    end
  end

  // error indication toward the link engine
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      crcError <= 1'b0;
    end else begin
      crcError <= |stat_reg[rcm_pkg::STAT_ERRC:rcm_pkg::STAT_ERR0];
    end
  end

  // read data, valid one cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !regRdStb) begin
      regRdData <= 8'h00;
    end else if (inArray(regAddr)) begin
      regRdData <= arrMem[regAddr[5:0]];
    end else if (regAddr == rcm_pkg::OFS_CTRL) begin
      regRdData <= ctrl_reg;
    end else if (regAddr == rcm_pkg::OFS_STAT) begin
      regRdData <= {uvAny, 2'b00, stat_reg};
    end else if (regAddr == rcm_pkg::OFS_CRC0) begin
      regRdData <= {4'h0, crc0_reg};
    end else if (regAddr == rcm_pkg::OFS_CRC1) begin
      regRdData <= {4'h0, crc1_reg};
    end else if (regAddr == rcm_pkg::OFS_MCRC) begin
      regRdData <= {4'h0, mirroredRegionCrc_reg};
    end else if (regAddr == rcm_pkg::OFS_CCRC) begin
      regRdData <= {3'h0, contRefValid_reg, contCrc_reg};
    end else begin
      regRdData <= 8'h00; // unmapped reads zero
    end
  end
endmodule : rcm_monitor

/* sim/rcm_monitor_assertions.sv */
// supply fault reaction checks bound to the monitor
`timescale 1ns/100ps
module rcm_monitor_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic busUvDet,
  input wire logic bufRailUvDet,
  input wire logic digRailUvDet,
  input wire logic anaRailUvDet,
  input wire logic bufCapLowDet,
  input wire logic txActive,
  input wire logic cmdRxActive,
  input wire logic respTxActive,
  input wire logic diagRespActive,
  input wire logic coreRstN,
  input wire logic decodeEnable,
  input wire logic cmdDiscard,
  input wire logic respAbort,
  input wire logic skipPeriodResp,
  input wire logic diagCmdFlush,
  input wire logic bufCapFault
);
  // fault causes seen at the inputs
  wire anyUv = busUvDet | bufRailUvDet | digRailUvDet | anaRailUvDet;
  wire cmdUv = anyUv & cmdRxActive;
  wire txUv = anyUv & (respTxActive | diagRespActive);
  wire capOn = txActive & bufCapLowDet;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // cap test hit, then flag two edges on
  sequence capHit;
    txActive && bufCapLowDet;
  endsequence
  sequence capSeen;
    ##2 bufCapFault;
  endsequence
  core_down_a: assert property (anyUv |=> !coreRstN)
    else $error("core reset missed");
  core_up_a: assert property (rst_n && !anyUv |=> coreRstN)
    else $error("core reset stuck");
  decode_resume_a: assert property (rst_n && !anyUv |=> decodeEnable)
    else $error("decode not resumed");
  discard_cause_a: assert property ($rose(cmdDiscard) |-> $past(cmdUv))
    else $error("discard without cause");
  abort_set_a: assert property (anyUv && respTxActive |=> respAbort)
    else $error("response not aborted");
  abort_cause_a: assert property ($rose(respAbort) |-> $past(txUv))
    else $error("abort without cause");
  skip_cause_a: assert property ($rose(skipPeriodResp) |-> $past(cmdUv))
    else $error("skip without cause");
  flush_edge_a: assert property (diagCmdFlush |-> $past(anyUv) && !$past(anyUv, 2))
    else $error("flush off the fault edge");
  cap_set_a: assert property (capHit |-> capSeen)
    else $error("cap fault not flagged");
  cap_cause_a: assert property ($rose(bufCapFault) |-> $past(capOn, 2))
    else $error("cap fault outside transmission");
endmodule : rcm_monitor_checker

bind rcm_monitor rcm_monitor_checker i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .busUvDet(busUvDet), .bufRailUvDet(bufRailUvDet),
  .digRailUvDet(digRailUvDet), .anaRailUvDet(anaRailUvDet), .bufCapLowDet(bufCapLowDet),
  .txActive(txActive), .cmdRxActive(cmdRxActive), .respTxActive(respTxActive),
  .diagRespActive(diagRespActive), .coreRstN(coreRstN), .decodeEnable(decodeEnable),
  .cmdDiscard(cmdDiscard), .respAbort(respAbort), .skipPeriodResp(skipPeriodResp),
  .diagCmdFlush(diagCmdFlush), .bufCapFault(bufCapFault)
);

/* sim/rcm_link_model.sv */
// link engine model framing commands, responses and diagnostics
`timescale 1ns/100ps
module rcm_link_model #(
  parameter int LEN = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [1:0] kind,
  output logic txActive,
  output logic cmdRxActive,
  output logic respTxActive,
  output logic diagRespActive,
  output logic periodStart
);
  logic [3:0] cntReg;
  logic [1:0] kindReg;
  // one frame of LEN cycles per go pulse, period start with each command
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cntReg <= 4'h0;
      kindReg <= 2'h0;
      periodStart <= 1'b0;
    end else begin
      periodStart <= go && (kind == 2'h0);
      if (go) begin
        cntReg <= LEN[3:0];
        kindReg <= kind;
      end else if (cntReg != 4'h0) begin
        cntReg <= cntReg - 4'h1;
      end
    end
  end
  // activity levels decoded from the frame kind
  assign cmdRxActive = (cntReg != 4'h0) && (kindReg == 2'h0);
  assign respTxActive = (cntReg != 4'h0) && (kindReg == 2'h1);
  assign diagRespActive = (cntReg != 4'h0) && (kindReg == 2'h2);
  assign txActive = respTxActive | diagRespActive;
endmodule : rcm_link_model

/* sim/rcm_monitor_tb.sv */
// self-checking testbench of the register crc and supply fault monitor
`timescale 1ns/100ps
module rcm_monitor_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [3:0] uvDet = 4'h0;
  logic bufCapLowDet = 1'b0;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic flushSeen = 1'b0;
  logic [7:0] regRdData, j;
  logic txActive, cmdRxActive, respTxActive, diagRespActive, periodStart;
  logic coreRstN, decodeEnable, cmdDiscard, respAbort, skipPeriodResp, diagCmdFlush;
  logic crcError, bufCapFault;
  logic [3:0] c;
  logic [7:0] img [0:63];
  int errorCnt = 0;
  int testsRun = 0;

  // clock and link partner
  initial forever #12.5 ref_clk = ~ref_clk;
  rcm_link_model i_link (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .kind(kind),
    .txActive(txActive), .cmdRxActive(cmdRxActive), .respTxActive(respTxActive),
    .diagRespActive(diagRespActive), .periodStart(periodStart));
  rcm_monitor i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .busUvDet(uvDet[0]), .bufRailUvDet(uvDet[1]), .digRailUvDet(uvDet[2]),
    .anaRailUvDet(uvDet[3]), .bufCapLowDet(bufCapLowDet), .txActive(txActive),
    .cmdRxActive(cmdRxActive), .respTxActive(respTxActive), .diagRespActive(diagRespActive),
    .periodStart(periodStart), .coreRstN(coreRstN), .decodeEnable(decodeEnable),
    .cmdDiscard(cmdDiscard), .respAbort(respAbort), .skipPeriodResp(skipPeriodResp),
    .diagCmdFlush(diagCmdFlush), .crcError(crcError), .bufCapFault(bufCapFault));
  // the flush is one cycle long, so keep a sticky copy, cleared as each frame starts
  always @(posedge ref_clk) flushSeen <= (flushSeen && !go) || diagCmdFlush;

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task clks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : clks
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 chk(regRdData, exp);
  endtask : rd
  task pulseGo(input logic [1:0] k);
    kind <= k;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask : pulseGo
  // crc over the image, msb first, ascending address
  function automatic logic [3:0] crcOf(input logic [7:0] lo, input logic [7:0] hi);
    logic [3:0] r;
    r = 4'h0;
    for (int a = lo; a <= hi; a++) begin
      for (int i = 7; i >= 0; i--) begin
        r = {r[2:0], 1'b0} ^ ((r[3] ^ img[a][i]) ? 4'h9 : 4'h0);
      end
    end
    return r;
  endfunction : crcOf
  // supply drop inside a frame, then a clean frame of the same kind
  task frame(input logic [1:0] md, input logic [1:0] k, input int det, input logic [3:0] e);
    wr(rcm_pkg::OFS_CTRL, {5'h00, md, 1'b0});
    pulseGo(k);
    clks(2);
    uvDet[det] <= 1'b1;
    clks(2);
    #1 chk({4'h0, cmdDiscard, respAbort, skipPeriodResp, flushSeen}, {4'h0, e});
    chk({6'h00, coreRstN, decodeEnable}, 8'h00);
    @(posedge ref_clk);
    uvDet[det] <= 1'b0;
    clks(10);
    pulseGo(k);
    clks(10);
    #1 chk({3'h0, cmdDiscard, respAbort, skipPeriodResp, coreRstN, decodeEnable}, 8'h03);
  endtask : frame
  task finalReport;
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finalReport

  // watchdog against a hung run
  initial begin
    clks(20000);
    errorCnt++;
    finalReport();
  end

  initial begin
    foreach (img[i]) img[i] = 8'h00;
    clks(3);
    rst_n <= 1'b1;
    rd(rcm_pkg::OFS_CTRL, rcm_pkg::CTRL_RST);
    rd(rcm_pkg::OFS_STAT, 8'h00);
    rd(8'h50, 8'h00);
    img[8'h30] = 8'h12;
    wr(8'h30, 8'h12);
    rd(8'h30, 8'h12);
    wr(rcm_pkg::OFS_LOCK, 8'hff);
    $display("test registers done");
    for (j = 8'h00; j < 8'h03; j++) begin
      img[{j[3:0], 4'h0}] = 8'h80 | j;
      img[{j[3:0], 4'hf}] = 8'h01;
      wr({j[3:0], 4'h0}, 8'h80 | j);
      wr({j[3:0], 4'hf}, 8'h01);
      wr(rcm_pkg::OFS_CRC0 + j, {4'h0, crcOf({j[3:0], 4'h0}, {j[3:0], 4'hf})});
    end
    clks(100);
    wr(rcm_pkg::OFS_STAT, 8'h1f);
    clks(100);
    rd(rcm_pkg::OFS_STAT, 8'h00);
    for (j = 8'h00; j < 8'h03; j++) begin
      c = crcOf({j[3:0], 4'h0}, {j[3:0], 4'hf});
      wr(rcm_pkg::OFS_CRC0 + j, {4'h0, c ^ 4'h1});
      clks(80);
      rd(rcm_pkg::OFS_STAT, 8'h02 << j);
      chk({7'h00, crcError}, 8'h01);
      wr(rcm_pkg::OFS_CRC0 + j, {4'h0, c});
      wr(rcm_pkg::OFS_STAT, 8'h1f);
      rd(rcm_pkg::OFS_STAT, 8'h00);
    end
    $display("test block crc done");
    frame(2'h0, 2'h0, 0, 4'h8);
    frame(2'h0, 2'h1, 1, 4'h4);
    frame(2'h0, 2'h2, 2, 4'h0);
    frame(2'h1, 2'h0, 3, 4'hb);
    frame(2'h1, 2'h1, 0, 4'h5);
    frame(2'h1, 2'h2, 1, 4'h5);
    frame(2'h2, 2'h1, 2, 4'h4);
    frame(2'h3, 2'h0, 3, 4'h0);
    $display("test supply faults done");
    clks(1);
    bufCapLowDet <= 1'b1;
    clks(3);
    rd(rcm_pkg::OFS_STAT, 8'h00);
    for (j = 8'h00; j < 8'h04; j++) begin
      wr(rcm_pkg::OFS_CTRL, {5'h00, j[1:0], 1'b0});
      pulseGo(2'h1);
      clks(10);
      rd(rcm_pkg::OFS_STAT, 8'h01);
      chk({7'h00, bufCapFault}, 8'h01);
      wr(rcm_pkg::OFS_STAT, 8'h01);
    end
    bufCapLowDet <= 1'b0;
    rd(rcm_pkg::OFS_STAT, 8'h00);
    $display("test buffer cap done");
    wr(rcm_pkg::OFS_CTRL, 8'h01);
    rd(rcm_pkg::OFS_CTRL, 8'h01);
    wr(rcm_pkg::OFS_MIRROR, 8'h55);
    wr(rcm_pkg::OFS_CRC0, 8'h00);
    rd(rcm_pkg::OFS_MIRROR, img[8'h20]);
    clks(250);
    rd(rcm_pkg::OFS_STAT, 8'h00);
    rd(rcm_pkg::OFS_CCRC, {3'h0, 1'b1, crcOf(8'h20, 8'h3e)});
    wr(rcm_pkg::OFS_LOCK, 8'h00);
    clks(250);
    rd(rcm_pkg::OFS_STAT, 8'h00);
    rd(rcm_pkg::OFS_CCRC, {3'h0, 1'b1, crcOf(8'h20, 8'h3e)});
    img[8'h31] = 8'h5a;
    wr(8'h31, 8'h5a);
    rd(8'h31, 8'h5a);
    clks(250);
    rd(rcm_pkg::OFS_STAT, 8'h00);
    rd(rcm_pkg::OFS_CCRC, {3'h0, 1'b1, crcOf(8'h20, 8'h3e)});
    $display("test continuous crc done");
    finalReport();
  end
endmodule : rcm_monitor_tb
